// ==== rsl_host.sv ====
// Host processor model: Avalon-MM master for register accesses
`timescale 1ns/1ps
`default_nettype none
module rsl_host (
  input wire logic clk,
  output logic [13:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = '0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = '0;
  end
  // One access held until waitrequest is seen low
  task automatic access(input logic wr, input logic [13:0] a, input logic [31:0] d,
      output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // Released lines carry no stale value
    avs_address <= ~a;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask
endmodule // rsl_host
`default_nettype wire

// ==== rsl_pkg.sv ====
// Shared constants for the receive signaling and LAPD buffer register bank
package rsl_pkg;
  localparam int RSL_NUM_SLOTS = 24;
  localparam int RSL_BUF_BYTES = 96;
  localparam int RSL_NUM_CTRL = 3;
  localparam int RSL_ADDR_W = 12;
  // Avalon byte addresses: printed offsets are not multiples of four, so index * 4
  localparam logic [11:0] RSL_SUBST_BASE_IDX = 12'h3c0;
  localparam logic [11:0] RSL_ARRAY_BASE_IDX = 12'h500;
  localparam logic [11:0] RSL_BUF0_IDX = 12'h600;
  localparam logic [11:0] RSL_SIGCTL_IDX = 12'h107;
  localparam logic [11:0] RSL_LAPDSEL_IDX = 12'h11b;
  localparam logic [11:0] RSL_SLOTCFG_BASE_IDX = 12'h3a0;
  localparam int RSL_SIGCTL_SFB_BIT = 7;
  localparam int RSL_CFG_DEB_BIT = 4;
  localparam int RSL_CFG_SEL_LSB = 2;
  localparam logic [3:0] RSL_NIB_RESET = 4'h0;
  localparam logic [3:0] RSL_ALL_ONES = 4'hf;
  localparam logic [1:0] RSL_SEL_ONES = 2'h0;
  localparam logic [1:0] RSL_SEL_16 = 2'h1;
  localparam logic [1:0] RSL_SEL_4 = 2'h2;
  localparam logic [1:0] RSL_SEL_2 = 2'h3;
  typedef enum logic [2:0] {
    RSL_IDLE = 3'b001,
    RSL_RESP = 3'b010,
    RSL_DONE = 3'b100
  } rsl_bus_e;
endpackage

// ==== rsl_regs.sv ====
// Register bank: signaling substitution, signaling array, LAPD buffer 0 port
`timescale 1ns/1ps
`default_nettype none
// Function
// - Substitute value bit 3 replaces A in 16, 4 and 2 code modes.
// - Substitute value bit 2 replaces B in 16 and 4 code modes.
// - Substitute value bit 1 replaces C in 16 code mode only.
// - Substitute value bit 0 replaces D in 16 code mode only.
// - Twenty-four substitute bytes, low nibble read/write, reset zero, upper reserved.
// - Array registers read back latest A B C D in bits 3 to 0.
// - Debounce with control bit 7 set updates entry only when two consecutive superframes agree.
// - Control bit 7 set with debounce on makes entries change only on superframe boundaries.
// - Debounce off or bit 7 clear updates entry at once on change.
// - Buffer 0 port serves whichever of three controllers is selected.
// - Written bytes go to transmit frame only while transmit buffer available flag is set, and never read back.
// - Repeated port reads return successive received bytes when pointer shows 0.
// - Each port access advances byte index, up to 96 bytes.
// - Select 00 forces ones, 01 ABCD, 10 AB, 11 A only.
// - Per-slot debounce enable bit turns debounce on at one.
module rsl_regs
  import rsl_pkg::*;
#(
  parameter int NUM_SLOTS = RSL_NUM_SLOTS,
  parameter int BUF_BYTES = RSL_BUF_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] rx_sig_bits,
  input wire logic [4:0] rx_sig_slot,
  input wire logic rx_sig_valid,
  input wire logic rx_superframe_end,
  input wire logic [7:0] rx_msg_byte,
  input wire logic rx_rd_addr_valid,
  input wire logic rx_buffer_pointer_flag,
  input wire logic tx_buffer_available_flag,
  input wire logic msg_start,
  output logic [7:0] tx_msg_byte,
  output logic [6:0] buf_index,
  output logic tx_msg_wr,
  output logic [1:0] lapd_ctrl_sel
);
  initial begin
    if (NUM_SLOTS < 1 || NUM_SLOTS > 32 || BUF_BYTES < 1 || BUF_BYTES > 128) begin
      $error("rsl_regs: unsupported parameters");
    end
  end

  logic [3:0] subst [NUM_SLOTS];
  logic [4:0] slot_cfg [NUM_SLOTS];
  logic [3:0] entry [NUM_SLOTS];
  logic [3:0] next_subst [NUM_SLOTS];
  logic [4:0] next_slot_cfg [NUM_SLOTS];
  logic sig_ctl_sfb;
  logic next_sig_ctl_sfb;
  logic [1:0] next_lapd_ctrl_sel;
  logic [6:0] next_buf_index;
  logic [7:0] next_tx_msg_byte;
  logic next_tx_msg_wr;
  logic [31:0] next_readdata;
  rsl_bus_e bus_state;
  rsl_bus_e next_bus_state;
  logic next_waitrequest;
  logic ptr_q;
  logic next_ptr_q;
  logic [11:0] idx;
  logic wr_hit;
  logic rd_hit;

  // Byte address to register index
  function automatic logic [11:0] addr_idx(input logic [13:0] a);
    addr_idx = a[13:2];
  endfunction

  function automatic logic in_range(input logic [11:0] i, input logic [11:0] base);
    in_range = (i >= base) && (i < base + 12'(NUM_SLOTS));
  endfunction

  function automatic logic [4:0] slot_of(input logic [11:0] i, input logic [11:0] base);
    slot_of = 5'(i - base);
  endfunction

  assign idx = addr_idx(avs_address);
  // Access commits in the RESP state, where waitrequest is low
  assign wr_hit = (bus_state == RSL_RESP) && avs_write;
  assign rd_hit = (bus_state == RSL_RESP) && avs_read;

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      rsl_sig_slot u_slot (
        .clk(clk),
        .rst(rst),
        .rx_sig(rx_sig_bits),
        .sig_valid(rx_sig_valid && rx_sig_slot == 5'(g)),
        .superframe_end(rx_superframe_end),
        .subst_value(subst[g]),
        .rx_substitution_select(slot_cfg[g][RSL_CFG_SEL_LSB +: 2]),
        .signaling_debounce_enable(slot_cfg[g][RSL_CFG_DEB_BIT]),
        .sf_boundary_mode(sig_ctl_sfb),
        .entry(entry[g])
      );
    end
  endgenerate

  // Bus handshake: waitrequest low only in RESP; DONE returns to IDLE after one cycle
  always_comb begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    case (bus_state)
      RSL_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state = RSL_RESP;
          next_waitrequest = 1'b0;
        end
      end
      RSL_RESP: next_bus_state = RSL_DONE;
      RSL_DONE: next_bus_state = RSL_IDLE;
      default: next_bus_state = RSL_IDLE;
    endcase
  end

  // Register writes
  always_comb begin
    next_sig_ctl_sfb = sig_ctl_sfb;
    next_lapd_ctrl_sel = lapd_ctrl_sel;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      next_subst[i] = subst[i];
      next_slot_cfg[i] = slot_cfg[i];
    end
    if (wr_hit) begin
      if (in_range(idx, RSL_SUBST_BASE_IDX)) begin
        next_subst[slot_of(idx, RSL_SUBST_BASE_IDX)] = avs_writedata[3:0];
      end
      if (in_range(idx, RSL_SLOTCFG_BASE_IDX)) begin
        next_slot_cfg[slot_of(idx, RSL_SLOTCFG_BASE_IDX)] = avs_writedata[4:0];
      end
      if (idx == RSL_SIGCTL_IDX) begin
        next_sig_ctl_sfb = avs_writedata[RSL_SIGCTL_SFB_BIT];
      end
      if (idx == RSL_LAPDSEL_IDX && avs_writedata[1:0] < 2'(RSL_NUM_CTRL)) begin
        next_lapd_ctrl_sel = avs_writedata[1:0];
      end
    end
  end

  // Buffer 0 port with auto-incrementing byte index
  always_comb begin
    next_buf_index = buf_index;
    next_tx_msg_byte = tx_msg_byte;
    next_tx_msg_wr = 1'b0;
    next_ptr_q = rx_buffer_pointer_flag;
    if (msg_start || (rx_buffer_pointer_flag != ptr_q)) begin
      next_buf_index = '0;
    end else if ((wr_hit || rd_hit) && idx == RSL_BUF0_IDX) begin
      if (buf_index < 7'(BUF_BYTES - 1)) begin
        next_buf_index = buf_index + 7'h01;
      end
      if (wr_hit && tx_buffer_available_flag) begin
        next_tx_msg_byte = avs_writedata[7:0];
        next_tx_msg_wr = 1'b1;
      end
    end
  end

  // Read data
  always_comb begin
    next_readdata = '0;
    if (rd_hit) begin
      if (in_range(idx, RSL_SUBST_BASE_IDX)) begin
        next_readdata[3:0] = subst[slot_of(idx, RSL_SUBST_BASE_IDX)];
      end else if (in_range(idx, RSL_ARRAY_BASE_IDX)) begin
        next_readdata[3:0] = entry[slot_of(idx, RSL_ARRAY_BASE_IDX)];
      end else if (in_range(idx, RSL_SLOTCFG_BASE_IDX)) begin
        next_readdata[4:0] = slot_cfg[slot_of(idx, RSL_SLOTCFG_BASE_IDX)];
      end else if (idx == RSL_SIGCTL_IDX) begin
        next_readdata[RSL_SIGCTL_SFB_BIT] = sig_ctl_sfb;
      end else if (idx == RSL_LAPDSEL_IDX) begin
        next_readdata[1:0] = lapd_ctrl_sel;
      end else if (idx == RSL_BUF0_IDX && rx_rd_addr_valid && !rx_buffer_pointer_flag) begin
        next_readdata[7:0] = rx_msg_byte;
      end
    end
  end

  // Readdata is registered at the same edge where waitrequest drops, so the
  // stored output at the RESP edge must reflect the request: drive a comb
  // copy, which ignores rx_rd_addr_valid for buffer 0, into the register while in IDLE to present data at RESP.
  logic [31:0] pre_readdata;
  always_comb begin
    pre_readdata = '0;
    if (in_range(idx, RSL_SUBST_BASE_IDX)) begin
      pre_readdata[3:0] = subst[slot_of(idx, RSL_SUBST_BASE_IDX)];
    end else if (in_range(idx, RSL_ARRAY_BASE_IDX)) begin
      pre_readdata[3:0] = entry[slot_of(idx, RSL_ARRAY_BASE_IDX)];
    end else if (in_range(idx, RSL_SLOTCFG_BASE_IDX)) begin
      pre_readdata[4:0] = slot_cfg[slot_of(idx, RSL_SLOTCFG_BASE_IDX)];
    end else if (idx == RSL_SIGCTL_IDX) begin
      pre_readdata[RSL_SIGCTL_SFB_BIT] = sig_ctl_sfb;
    end else if (idx == RSL_LAPDSEL_IDX) begin
      pre_readdata[1:0] = lapd_ctrl_sel;
    end else if (idx == RSL_BUF0_IDX && !rx_buffer_pointer_flag) begin
      pre_readdata[7:0] = rx_msg_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_state <= RSL_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      sig_ctl_sfb <= 1'b0;
      lapd_ctrl_sel <= 2'h0;
      buf_index <= '0;
      tx_msg_byte <= 8'h00;
      tx_msg_wr <= 1'b0;
      ptr_q <= 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        subst[i] <= RSL_NIB_RESET;
        slot_cfg[i] <= 5'h00;
      end
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= (bus_state == RSL_IDLE && avs_read) ? pre_readdata : next_readdata;
      sig_ctl_sfb <= next_sig_ctl_sfb;
      lapd_ctrl_sel <= next_lapd_ctrl_sel;
      buf_index <= next_buf_index;
      tx_msg_byte <= next_tx_msg_byte;
      tx_msg_wr <= next_tx_msg_wr;
      ptr_q <= next_ptr_q;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        subst[i] <= next_subst[i];
        slot_cfg[i] <= next_slot_cfg[i];
      end
    end
  end

  a_wait_pulse: assert property (@(posedge clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest low too long");
  a_subst_write: assert property (@(posedge clk) disable iff (rst)
    (wr_hit && in_range(idx, RSL_SUBST_BASE_IDX))
    |=> subst[$past(slot_of(idx, RSL_SUBST_BASE_IDX))] == $past(avs_writedata[3:0]))
    else $error("substitute write lost");
  a_index_step: assert property (@(posedge clk) disable iff (rst)
    ((wr_hit || rd_hit) && idx == RSL_BUF0_IDX && !msg_start &&
     rx_buffer_pointer_flag == ptr_q && buf_index < 7'(BUF_BYTES - 1))
    |=> buf_index == $past(buf_index) + 7'h01)
    else $error("byte index did not advance");
  a_index_clear: assert property (@(posedge clk) disable iff (rst)
    msg_start |=> buf_index == 7'h00)
    else $error("byte index not cleared");
  a_tx_no_read: assert property (@(posedge clk) disable iff (rst)
    (rd_hit && idx == RSL_BUF0_IDX && rx_buffer_pointer_flag) |=> avs_readdata == 32'h0)
    else $error("transmit data read back");
  a_resv_zero: assert property (@(posedge clk) disable iff (rst)
    (!avs_waitrequest && avs_read && (in_range(idx, RSL_SUBST_BASE_IDX) ||
     in_range(idx, RSL_ARRAY_BASE_IDX))) |-> avs_readdata[31:4] == 28'h0)
    else $error("reserved bits nonzero");
endmodule // rsl_regs
`default_nettype wire

// ==== rsl_regs_test.sv ====
// Testbench for the signaling and LAPD buffer register bank
`timescale 1ns/1ps
`default_nettype none
module rsl_regs_test;
  import rsl_pkg::*;
  logic clk = 1'h0, rst = 1'h1;
  logic [13:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, tx_msg_wr;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] rx_sig_bits = 4'h0;
  logic [4:0] rx_sig_slot = 5'h0;
  logic rx_sig_valid = 1'h0, rx_superframe_end = 1'h0, rx_rd_addr_valid = 1'h1;
  logic rx_buffer_pointer_flag = 1'h0, tx_buffer_available_flag = 1'h0, msg_start = 1'h0;
  logic [7:0] rx_msg_byte = 8'h0, tx_msg_byte;
  logic [6:0] buf_index;
  logic [1:0] lapd_ctrl_sel;
  logic [7:0] txq[$];
  int n_errors = 0, checks = 0;
  always #5 clk = ~clk;
  rsl_regs i_rsl_regs (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .rx_sig_bits, .rx_sig_slot, .rx_sig_valid,
    .rx_superframe_end, .rx_msg_byte, .rx_rd_addr_valid, .rx_buffer_pointer_flag,
    .tx_buffer_available_flag, .msg_start, .tx_msg_byte, .buf_index, .tx_msg_wr,
    .lapd_ctrl_sel);
  rsl_host i_rsl_host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  // Message memory and transmit byte capture
  always @(posedge clk) begin
    rx_msg_byte <= 8'h5a ^ {1'h0, buf_index};
    if (tx_msg_wr === 1'h1) txq.push_back(tx_msg_byte);
  end
  function automatic logic [13:0] adr(input logic [11:0] base, input int i);
    return {base + 12'(i), 2'h0};
  endfunction
  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    chk_reg({24'h0, g}, {24'h0, e});
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_rsl_host.access(1'h1, a, d, q);
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_rsl_host.access(1'h0, a, 32'h0, q);
    chk_reg(q, e);
  endtask
  task automatic sig(input int s, input logic [3:0] b, input logic sf);
    rx_sig_slot <= 5'(s);
    rx_sig_bits <= b;
    rx_sig_valid <= !sf;
    rx_superframe_end <= sf;
    @(posedge clk);
    rx_sig_valid <= 1'h0;
    rx_superframe_end <= 1'h0;
    rx_sig_bits <= ~b;
    @(posedge clk);
  endtask
  task automatic pulse_start;
    msg_start <= 1'h1;
    @(posedge clk);
    msg_start <= 1'h0;
    @(posedge clk);
  endtask
  task automatic t_reset_and_reserved;
    rd_chk(adr(RSL_SUBST_BASE_IDX, 0), 32'h0);
    rd_chk(adr(RSL_ARRAY_BASE_IDX, 23), 32'h0);
    rd_chk(adr(12'hfff, 0), 32'h0);
    wr(adr(RSL_SUBST_BASE_IDX, 23), 32'hff);
    rd_chk(adr(RSL_SUBST_BASE_IDX, 23), 32'hf);
  endtask
  task automatic t_modes;
    logic [31:0] exp[4] = '{32'hf, 32'ha, 32'h9, 32'hd};
    for (int s = 0; s < 4; s++) begin
      wr(adr(RSL_SLOTCFG_BASE_IDX, s), 32'(s) << 2);
      wr(adr(RSL_SUBST_BASE_IDX, s), 32'ha);
      sig(s, 4'h5, 1'h0);
      // Array is read only after the slot's signaling source is set up
      rd_chk(adr(RSL_ARRAY_BASE_IDX, s), exp[s]);
    end
  endtask
  task automatic t_debounce;
    logic [13:0] a = adr(RSL_ARRAY_BASE_IDX, 5);
    wr(adr(RSL_SLOTCFG_BASE_IDX, 5), 32'h1c);
    wr({RSL_SIGCTL_IDX, 2'h0}, 32'h80);
    sig(5, 4'h3, 1'h1);
    rd_chk(a, 32'h0);
    sig(5, 4'h3, 1'h1);
    rd_chk(a, 32'h3);
    sig(5, 4'h5, 1'h0);
    rd_chk(a, 32'h3);
    sig(5, 4'h5, 1'h1);
    sig(5, 4'h3, 1'h1);
    rd_chk(a, 32'h3);
    wr(adr(RSL_SLOTCFG_BASE_IDX, 5), 32'hc);
    sig(5, 4'h1, 1'h0);
    rd_chk(a, 32'h1);
    wr(adr(RSL_SLOTCFG_BASE_IDX, 5), 32'h1c);
    wr({RSL_SIGCTL_IDX, 2'h0}, 32'h0);
    sig(5, 4'h6, 1'h0);
    rd_chk(a, 32'h6);
  endtask
  task automatic t_lapd;
    logic [13:0] p = {RSL_BUF0_IDX, 2'h0};
    wr({RSL_LAPDSEL_IDX, 2'h0}, 32'h2);
    wr({RSL_LAPDSEL_IDX, 2'h0}, 32'h3);
    chk_pin({6'h0, lapd_ctrl_sel}, 8'h2);
    pulse_start();
    // Pointer shows buffer 0 after end of transfer
    for (int i = 0; i < 96; i++) rd_chk(p, 32'(8'h5a ^ 8'(i)));
    chk_pin({1'h0, buf_index}, 8'h5f);
    rx_buffer_pointer_flag <= 1'h1;
    repeat (2) @(posedge clk);
    chk_pin({1'h0, buf_index}, 8'h0);
    rd_chk(p, 32'h0);
    tx_buffer_available_flag <= 1'h1;
    pulse_start();
    for (int i = 1; i < 4; i++) wr(p, 32'hff00 | 32'(i * 17));
    tx_buffer_available_flag <= 1'h0;
    wr(p, 32'h44);
    @(posedge clk);
    chk_pin(8'(txq.size()), 8'h3);
    for (int i = 0; i < 3; i++) chk_pin(txq[i], 8'((i + 1) * 17));
    chk_pin({1'h0, buf_index}, 8'h4);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset_and_reserved();
    t_modes();
    t_debounce();
    t_lapd();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule // rsl_regs_test
`default_nettype wire

// ==== rsl_sig_slot.sv ====
// One timeslot's signaling substitution and debounced array entry
`timescale 1ns/1ps
`default_nettype none
module rsl_sig_slot
  import rsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] rx_sig,
  input wire logic sig_valid,
  input wire logic superframe_end,
  input wire logic [3:0] subst_value,
  input wire logic [1:0] rx_substitution_select,
  input wire logic signaling_debounce_enable,
  input wire logic sf_boundary_mode,
  output logic [3:0] entry
);
  logic [3:0] src;
  logic [3:0] prev_sf;
  logic [3:0] next_entry;
  logic [3:0] next_prev_sf;

  always_comb begin
    case (rx_substitution_select)
      RSL_SEL_ONES: src = RSL_ALL_ONES;
      RSL_SEL_16: src = subst_value;
      RSL_SEL_4: src = {subst_value[3:2], rx_sig[1:0]};
      RSL_SEL_2: src = {subst_value[3], rx_sig[2:0]};
      default: src = rx_sig;
    endcase
  end

  always_comb begin
    next_entry = entry;
    next_prev_sf = prev_sf;
    if (signaling_debounce_enable && sf_boundary_mode) begin
      if (superframe_end) begin
        next_prev_sf = src;
        if (src == prev_sf) begin
          next_entry = src;
        end
      end
    end else if (sig_valid) begin
      next_entry = src;
      next_prev_sf = src;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      entry <= RSL_NIB_RESET;
      prev_sf <= RSL_NIB_RESET;
    end else begin
      entry <= next_entry;
      prev_sf <= next_prev_sf;
    end
  end

  a_deb_hold: assert property (@(posedge clk) disable iff (rst)
    (signaling_debounce_enable && sf_boundary_mode && !superframe_end) |=> $stable(entry))
    else $error("entry changed off boundary");
  a_imm_update: assert property (@(posedge clk) disable iff (rst)
    (!(signaling_debounce_enable && sf_boundary_mode) && sig_valid) |=> entry == $past(src))
    else $error("immediate update missed");
  a_ones_sel: assert property (@(posedge clk) disable iff (rst)
    (rx_substitution_select == RSL_SEL_ONES && sig_valid &&
     !(signaling_debounce_enable && sf_boundary_mode)) |=> entry == RSL_ALL_ONES)
    else $error("all ones substitution lost");
endmodule // rsl_sig_slot
`default_nettype wire
